// File: logic/conv_ctrl_regs.svh
// constants for the simultaneous-sampling converter control block
// Function
// (R1) busy rises on convert start rising edge, stays high until all picked channels done
// (R2) first_result_flag high exactly while result pointer selects first result
// (R3) convert start rising edge holds all four track-and-holds and starts converting
// (R4) channel selection captured at convert start rising edge, used for whole sequence
// (R5) device selected on parallel bus only while chip select low
// (R6) data outputs driven only while read and chip select low
// (R7) host keeps write strobe high during any read access
// (R8) write strobe rising edge, chip select low, read high loads low_data_lines
// (R9) source select 0 takes sequence from hw_channel_pick pins
// (R10) source select 1 takes sequence from channel select register
// (R11) low_power_request high is normal, low is standby
// (R12) bit zero enables channel 1, bit three enables channel 4
// (R13) end-of-conversion low pulse after each channel conversion
// (R14) each channel conversion takes 14 master clock cycles
// (R15) clock_source_pick 0 uses internal clock, 1 external conversion clock
// (R16) result pointer advances per read over picked channels, resets per sequence
// (R17) enabled channels converted in ascending order, disabled ones skipped
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH
`define CONV_CHANNELS 4
`define CONV_DATA_BITS 12
`define CONV_MCLK_CYCLES 14
`define CONV_EOC_PULSE_NS 75
`define CONV_CLK_PERIOD_NS 8
`define CONV_EOC_CYCLES ((`CONV_EOC_PULSE_NS + `CONV_CLK_PERIOD_NS - 1) / `CONV_CLK_PERIOD_NS)
`define CONV_CHSEL_RESET 4'h0
`define CONV_FIFO_DEPTH 16
`endif

// File: logic/conv_ctrl_pkg.sv
// types for the converter control block
package conv_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_EOC
  } conv_state_t;
endpackage

// File: logic/result_fifo.sv
// synchronous fifo for conversion results
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // clock, reset, enable and flush
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (flush_i)
    begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
    else
    begin
      if (push)
        wr_d = wr_q + AW'(1);
      if (pop)
        rd_d = rd_q + AW'(1);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (ce_i)
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset: contents are only read when counted valid
  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i && push && !flush_i)
      mem_q[wr_q] <= in_data_i;
  end
endmodule

// File: logic/conv_ctrl.sv
// convert-start, sequencing and parallel host interface of the four-channel converter
`include "conv_ctrl_regs.svh"
module conv_ctrl #(
  parameter int CHANNELS = `CONV_CHANNELS,
  parameter int DATA_BITS = `CONV_DATA_BITS,
  parameter int MCLK_CYCLES = `CONV_MCLK_CYCLES,
  parameter int FIFO_DEPTH = `CONV_FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // conversion control pins
  input wire logic convert_start_i,
  input wire logic [CHANNELS-1:0] hw_channel_pick_i,
  input wire logic sw_source_pick_i,
  input wire logic low_power_request_n_i,
  input wire logic clock_source_pick_i,
  input wire logic external_conversion_clock_i,
  output logic busy_o,
  output logic eoc_n_o,
  output logic first_result_flag_o,
  output logic [CHANNELS-1:0] track_hold_o,
  output logic standby_o,
  // parallel host bus
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [DATA_BITS-1:0] data_i,
  output logic [DATA_BITS-1:0] data_o,
  output logic [DATA_BITS-1:0] data_oe_o,
  // result source from the analog core
  input wire logic [DATA_BITS-1:0] sample_i
);
  localparam int CW = $clog2(CHANNELS);
  localparam int EW = 8;
  localparam int RW = DATA_BITS + CW;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each
  localparam int NS = 7 + CHANNELS;
  logic [NS-1:0] sync1_q, sync2_q, pin_raw;
  // write strobe has its own pair below, kept in step with the data lines
  assign pin_raw = {convert_start_i, sw_source_pick_i, low_power_request_n_i, clock_source_pick_i,
                    external_conversion_clock_i, cs_n_i, rd_n_i, hw_channel_pick_i};
  logic wr_s1_q, wr_s2_q;
  logic [DATA_BITS-1:0] dat_s1_q, dat_s2_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
      wr_s1_q <= 1'b1;
      wr_s2_q <= 1'b1;
      dat_s1_q <= '0;
      dat_s2_q <= '0;
    end
    else if (ce_i)
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      wr_s1_q <= wr_n_i;
      wr_s2_q <= wr_s1_q;
      dat_s1_q <= data_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  logic cst_s, src_s, low_power_request_n_s, clksel_s, xclk_s, cs_n_s, rd_n_s;
  logic [CHANNELS-1:0] pick_s;
  assign cst_s = sync2_q[NS-1];
  assign src_s = sync2_q[NS-2];
  assign low_power_request_n_s = sync2_q[NS-3];
  assign clksel_s = sync2_q[NS-4];
  assign xclk_s = sync2_q[NS-5];
  assign cs_n_s = sync2_q[NS-6];
  assign rd_n_s = sync2_q[NS-7];
  assign pick_s = sync2_q[CHANNELS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // edge history, master clock tick, channel select register
  logic cst_q, xclk_q, wr_q, rd_q;
  logic [CHANNELS-1:0] chsel_q, chsel_d;
  logic cst_rise, xclk_rise, wr_rise, rd_rise, selected, mclk_tick;

  assign selected = !cs_n_s; // [R5]
  assign cst_rise = cst_s && !cst_q;
  assign xclk_rise = xclk_s && !xclk_q;
  assign wr_rise = wr_s2_q && !wr_q;
  assign rd_rise = rd_n_s && !rd_q;
  // internal master clock is the system clock; an external one counts on its rising edges
  assign mclk_tick = clksel_s ? xclk_rise : 1'b1; // [R15]
  assign standby_o = !low_power_request_n_s; // [R11]

  always_comb
  begin
    chsel_d = chsel_q;
    if (wr_rise && selected && rd_n_s) // [R8]
      chsel_d = dat_s2_q[CHANNELS-1:0]; // [R12]
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // match the synchronisers' preset so no false edge follows reset
      cst_q <= 1'b1;
      xclk_q <= 1'b1;
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      chsel_q <= `CONV_CHSEL_RESET;
    end
    else if (ce_i)
    begin
      cst_q <= cst_s;
      xclk_q <= xclk_s;
      wr_q <= wr_s2_q;
      rd_q <= rd_n_s;
      chsel_q <= chsel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  function automatic logic [CW:0] next_channel(input logic [CHANNELS-1:0] mask, input logic [CW:0] from);
    logic [CW:0] r;
    r = (CW+1)'(CHANNELS);
    for (int i = CHANNELS - 1; i >= 0; i--)
      if (mask[i] && (i >= int'(from)))
        r = (CW+1)'(i);
    return r;
  endfunction

  conv_ctrl_pkg::conv_state_t st_q, st_d;
  logic [CHANNELS-1:0] seq_q, seq_d;
  logic [CW:0] ch_q, ch_d;
  logic [4:0] mcnt_q, mcnt_d;
  logic [EW-1:0] ecnt_q, ecnt_d;
  logic busy_d, push;
  logic [CW:0] nxt;

  assign nxt = next_channel(seq_q, ch_q + (CW+1)'(1)); // [R17]
  assign push = (st_q == conv_ctrl_pkg::ST_CONVERT) && mclk_tick && (mcnt_q == 5'(MCLK_CYCLES - 1));

  always_comb
  begin
    st_d = st_q;
    seq_d = seq_q;
    ch_d = ch_q;
    mcnt_d = mcnt_q;
    ecnt_d = ecnt_q;
    busy_d = busy_o;
    unique case (st_q)
      conv_ctrl_pkg::ST_IDLE:
      begin
        if (cst_rise && low_power_request_n_s) // [R3]
        begin
          seq_d = src_s ? chsel_q : pick_s; // [R4] [R9] [R10]
          ch_d = next_channel(src_s ? chsel_q : pick_s, '0); // [R17]
          mcnt_d = '0;
          if ((src_s ? chsel_q : pick_s) != '0)
          begin
            busy_d = 1'b1; // [R1]
            st_d = conv_ctrl_pkg::ST_CONVERT;
          end
        end
      end
      conv_ctrl_pkg::ST_CONVERT:
      begin
        if (mclk_tick)
        begin
          mcnt_d = mcnt_q + 5'd1; // [R14]
          if (push)
          begin
            mcnt_d = '0;
            ecnt_d = EW'(`CONV_EOC_CYCLES);
            st_d = conv_ctrl_pkg::ST_EOC;
          end
        end
      end
      conv_ctrl_pkg::ST_EOC:
      begin
        ecnt_d = ecnt_q - EW'(1); // [R13]
        if (ecnt_q == EW'(1))
        begin
          ch_d = nxt;
          if (nxt == (CW+1)'(CHANNELS))
          begin
            busy_d = 1'b0; // [R1]
            st_d = conv_ctrl_pkg::ST_IDLE;
          end
          else
            st_d = conv_ctrl_pkg::ST_CONVERT;
        end
      end
      default:
        st_d = conv_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= conv_ctrl_pkg::ST_IDLE;
      seq_q <= '0;
      ch_q <= '0;
      mcnt_q <= '0;
      ecnt_q <= '0;
      busy_o <= 1'b0;
    end
    else if (ce_i)
    begin
      st_q <= st_d;
      seq_q <= seq_d;
      ch_q <= ch_d;
      mcnt_q <= mcnt_d;
      ecnt_q <= ecnt_d;
      busy_o <= busy_d;
    end
  end

  assign eoc_n_o = (st_q != conv_ctrl_pkg::ST_EOC); // [R13]
  // all holds released together only when idle, so sampling instants match
  assign track_hold_o = {CHANNELS{st_q != conv_ctrl_pkg::ST_IDLE}}; // [R3]

  ////////////////////////////////////////////////////////////////////////////
  // result buffer and read pointer
  logic f_ready, f_valid, f_pop, first_q, first_d;
  logic [RW-1:0] f_data;
  logic [DATA_BITS-1:0] dout_q, dout_d;

  // at most one result per channel per sequence, so the buffer never fills
  result_fifo #(
    .WIDTH(RW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .flush_i(cst_rise && st_q == conv_ctrl_pkg::ST_IDLE), // [R16]
    .in_valid_i(push),
    .in_ready_o(f_ready),
    .in_data_i({ch_q[CW-1:0], sample_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  assign f_pop = rd_rise && selected; // [R16]

  always_comb
  begin
    first_d = first_q;
    dout_d = f_valid ? f_data[DATA_BITS-1:0] : '0;
    if (cst_rise && st_q == conv_ctrl_pkg::ST_IDLE)
      first_d = 1'b1; // [R16]
    else if (f_pop)
      first_d = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      first_q <= 1'b0;
      dout_q <= '0;
    end
    else if (ce_i)
    begin
      first_q <= first_d;
      dout_q <= dout_d;
    end
  end

  assign first_result_flag_o = first_q && f_valid; // [R2]
  assign data_o = dout_q;
  assign data_oe_o = {DATA_BITS{selected && !rd_n_s && wr_s2_q}}; // [R6] [R7]
  logic unused;
  assign unused = f_ready;
endmodule

// File: test/conv_ctrl_chk.sv
// port assertions for the converter control block
module conv_ctrl_chk #(
  parameter int CHANNELS = 4,
  parameter int DATA_BITS = 12
) (
  // watched ports
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clock_source_pick_i,
  input wire logic low_power_request_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic busy_o,
  input wire logic eoc_n_o,
  input wire logic standby_o,
  input wire logic [CHANNELS-1:0] track_hold_o,
  input wire logic [DATA_BITS-1:0] data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  // counts consecutive low samples of the end-of-conversion pulse
  logic [7:0] low_cnt;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      low_cnt <= 8'h00;
    else
      low_cnt <= eoc_n_o ? 8'h00 : low_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  sequence eoc_pulse_s;
    ##9 (!eoc_n_o && low_cnt == 8'h09) ##1 eoc_n_o;
  endsequence
  sequence first_eoc_s;
    eoc_n_o [*8] ##1 eoc_n_o [*6] ##1 !eoc_n_o;
  endsequence
  ////////////////////////////////////////////////////////////////
  eoc_width_a: assert property ($fell(eoc_n_o) |-> eoc_pulse_s)
    else $error("eoc pulse width wrong");
  first_eoc_a: assert property ($rose(busy_o) && !clock_source_pick_i |-> first_eoc_s)
    else $error("first conversion length wrong");
  eoc_busy_a: assert property (!eoc_n_o |-> busy_o)
    else $error("eoc outside busy");
  hold_start_a: assert property ($rose(busy_o) |-> track_hold_o == '1)
    else $error("holds not all set at start");
  standby_block_a: assert property (standby_o |=> !$rose(busy_o))
    else $error("start taken in standby");
  standby_on_a: assert property ((!low_power_request_n_i) [*3] |-> standby_o)
    else $error("standby not entered");
  oe_off_a: assert property ((cs_n_i || rd_n_i) [*4] |-> data_oe_o == '0)
    else $error("bus driven while not read");
  oe_select_a: assert property (data_oe_o != '0 |-> !$past(cs_n_i, 2) && !$past(rd_n_i, 2))
    else $error("bus driven while not selected");
endmodule
bind conv_ctrl conv_ctrl_chk #(.CHANNELS(CHANNELS), .DATA_BITS(DATA_BITS)) i_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clock_source_pick_i(clock_source_pick_i),
  .low_power_request_n_i(low_power_request_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
  .busy_o(busy_o), .eoc_n_o(eoc_n_o), .standby_o(standby_o), .track_hold_o(track_hold_o),
  .data_oe_o(data_oe_o)
);

// File: test/host_model.sv
// host processor model on the parallel bus
module host_model (
  // clock
  input wire logic clk_sys_i,
  // strobes and data
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [11:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 12'h5a5;
  end
  task automatic write_sel(input logic [3:0] sel);
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    data_o <= {8'h00, sel};
    wr_n_o <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    wr_n_o <= 1'b1;
    // data held past the synchronised edge
    repeat (3) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    data_o <= ~data_o;
  endtask
  task automatic read_word();
    @(posedge clk_sys_i);
    wr_n_o <= 1'b1;
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rd_n_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    @(posedge clk_sys_i);
  endtask
endmodule

// File: test/tb.sv
// self-checking bench for the converter control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic src = 1'b0;
  logic lp_n = 1'b1;
  logic csrc = 1'b0;
  logic xclk = 1'b0;
  logic eoc_q = 1'b1;
  logic busy, eoc_n, flag, low_power_request, cs_n, rd_n, wr_n;
  logic [3:0] pins = 4'h1;
  logic [3:0] hold;
  logic [11:0] din, dout, oe;
  logic [11:0] smp = 12'h000;
  logic [11:0] exp_q[$];
  integer seed = 32'hb335_788f;
  int failures = 0;
  int compares = 0;
  int neoc = 0;
  int oe_cnt = 0;
  initial forever #4 clk = ~clk;
  // slow conversion clock, runs only while selected
  always @(posedge clk) if (csrc) xclk <= ~xclk;
  conv_ctrl i_dut (
    .clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .convert_start_i(start),
    .hw_channel_pick_i(pins), .sw_source_pick_i(src), .low_power_request_n_i(lp_n),
    .clock_source_pick_i(csrc), .external_conversion_clock_i(xclk), .busy_o(busy),
    .eoc_n_o(eoc_n), .first_result_flag_o(flag), .track_hold_o(hold), .standby_o(low_power_request),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(din), .data_o(dout),
    .data_oe_o(oe), .sample_i(smp)
  );
  host_model i_host (.clk_sys_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(din));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] expv);
    compares++;
    if (seen !== expv)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // each channel end bumps the analog sample so results show their order
  always @(posedge clk)
  begin
    eoc_q <= eoc_n;
    oe_cnt <= (oe === 12'hfff) ? oe_cnt + 1 : 0;
    if (oe_cnt == 1 && oe === 12'hfff && exp_q.size() > 0)
      chk(dout, exp_q.pop_front());
    if (eoc_n === 1'b1 && eoc_q === 1'b0)
    begin
      neoc <= neoc + 1;
      smp <= smp + 12'h001;
    end
  end
  task automatic run_seq(input logic s, input logic x, input logic [3:0] sel);
    int n;
    logic [11:0] b;
    b = 12'($random(seed));
    i_host.write_sel(s ? sel : ~sel);
    pins <= s ? ~sel : sel;
    src <= s;
    csrc <= x;
    smp <= b;
    neoc <= 0;
    repeat (4) @(posedge clk);
    start <= 1'b1;
    repeat (6) @(posedge clk);
    start <= 1'b0;
    pins <= ~pins;
    chk(12'(busy), 12'h001);
    chk(12'(hold), 12'h00f);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(12'(neoc), 12'($countones(sel)));
    chk(12'(flag), 12'h001);
    for (n = 0; n < $countones(sel); n++)
    begin
      exp_q.push_back(b + 12'(n));
      i_host.read_word();
      chk(12'(flag), 12'h000);
    end
    chk(12'(exp_q.size()), 12'h000);
  endtask
  initial
  begin
    int i;
    logic [3:0] sel;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      sel = (i == 4) ? 4'hf : 4'($random(seed)) | 4'(1 << (i % 4));
      run_seq(i[0], i == 7, sel);
    end
    lp_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk(12'(low_power_request), 12'h001);
    start <= 1'b1;
    repeat (8) @(posedge clk);
    chk(12'(busy), 12'h000);
    start <= 1'b0;
    lp_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(12'(low_power_request), 12'h000);
    report_and_stop();
  end
  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule
